// File: src/pll_cfg_top.sv
// axi4-lite configuration block for ratio format and loop bandwidth
`timescale 1ns/100ps
module pll_cfg_top
   import pll_cfg_pkg::*;
#(
   parameter int AW = 8
) (
   input wire logic CLK_SYS_I, // system clock
   input wire logic RST_N_I, // async reset, active low
   input wire logic [AW-1:0] S_AXI_AWADDR_I, // write address
   input wire logic S_AXI_AWVALID_I, // write address valid
   output logic S_AXI_AWREADY_O, // write address ready
   input wire logic [31:0] S_AXI_WDATA_I, // write data
   input wire logic [3:0] S_AXI_WSTRB_I, // write strobes
   input wire logic S_AXI_WVALID_I, // write data valid
   output logic S_AXI_WREADY_O, // write data ready
   output logic [1:0] S_AXI_BRESP_O, // write response
   output logic S_AXI_BVALID_O, // write response valid
   input wire logic S_AXI_BREADY_I, // write response ready
   input wire logic [AW-1:0] S_AXI_ARADDR_I, // read address
   input wire logic S_AXI_ARVALID_I, // read address valid
   output logic S_AXI_ARREADY_O, // read address ready
   output logic [31:0] S_AXI_RDATA_O, // read data
   output logic [1:0] S_AXI_RRESP_O, // read response
   output logic S_AXI_RVALID_O, // read data valid
   input wire logic S_AXI_RREADY_I, // read data ready
   input wire logic PLL_LOCK_I, // lock flag from the loop core
   output logic RUN_O, // normal operation allowed
   output logic RATIO_FMT_O, // ratio format in use
   output logic [19:0] RATIO_INT_O, // ratio integer part
   output logic [19:0] RATIO_FRAC_O, // ratio fraction, left aligned
   output logic [2:0] LOOP_BW_CODE_O, // applied bandwidth code
   output logic [7:0] MIN_BW_HZ_O // applied minimum bandwidth in Hz
);
   // ---------------------------------------------------------------
   // bus slave state
   // ---------------------------------------------------------------
   logic awready_q, awready_d, wready_q, wready_d;
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [AW-1:0] waddr_q, waddr_d, raddr;
   logic [7:0] wdata_q, wdata_d;
   logic wstb_q, wstb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic arready_q, arready_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic aw_fire, w_fire, ar_fire, wr_en, wr_ok, rd_ok;
   logic [5:0] widx, ridx;

   // ---------------------------------------------------------------
   // configuration state
   // ---------------------------------------------------------------
   logic en1_q, en1_d, en2_q, en2_d, en3_q, en3_d;
   logic fmt_q, fmt_d, run_q, run_d, lock_q;
   logic [2:0] bw_q, bw_d, applied_q, applied_d;
   logic [7:0] hz_q, hz_d;
   logic [31:0] ratio_q, ratio_d;
   logic fmt_out_q;
   logic [19:0] int_q, frac_q, int_c, frac_c;

   function automatic logic idx_mapped(input logic [5:0] idx);
      unique case (idx)
         IDX_ENABLE1, IDX_GLOBAL, IDX_RATIO0, IDX_RATIO1, IDX_RATIO2,
         IDX_RATIO3, IDX_FUNC1, IDX_FUNC2, IDX_BW: idx_mapped = 1'b1;
         default: idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   assign aw_fire = S_AXI_AWVALID_I & awready_q;
   assign w_fire = S_AXI_WVALID_I & wready_q;
   assign ar_fire = S_AXI_ARVALID_I & arready_q;
   assign raddr = S_AXI_ARADDR_I;
   assign widx = waddr_d[7:2];
   assign ridx = raddr[7:2];
   assign wr_ok = idx_mapped(widx);
   assign rd_ok = idx_mapped(ridx) | (ridx == IDX_STATUS);

   // ---------------------------------------------------------------
   // axi4-lite handshakes
   // ---------------------------------------------------------------
   // address and data are taken in either order; the write commits when
   // both are held, so a late strobe never lands on a stale address
   always_comb begin
      waddr_d = aw_fire ? S_AXI_AWADDR_I : waddr_q;
      wdata_d = w_fire ? S_AXI_WDATA_I[7:0] : wdata_q;
      wstb_d = w_fire ? S_AXI_WSTRB_I[0] : wstb_q;
      aw_full_d = aw_full_q | aw_fire;
      w_full_d = w_full_q | w_fire;
      wr_en = aw_full_d & w_full_d & ~bvalid_q;
      bresp_d = bresp_q;
      bvalid_d = bvalid_q & ~S_AXI_BREADY_I;
      if (wr_en) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      awready_d = ~aw_full_d & ~bvalid_d;
      wready_d = ~w_full_d & ~bvalid_d;
      rvalid_d = rvalid_q & ~S_AXI_RREADY_I;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_fire) begin
         rvalid_d = 1'b1;
         rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
         unique case (ridx)
            IDX_ENABLE1: rdata_d = 32'(en1_q) << EN1_BIT;
            IDX_GLOBAL: rdata_d = 32'(en2_q) << EN2_BIT;
            IDX_RATIO0: rdata_d = {24'h000000, ratio_q[31:24]};
            IDX_RATIO1: rdata_d = {24'h000000, ratio_q[23:16]};
            IDX_RATIO2: rdata_d = {24'h000000, ratio_q[15:8]};
            IDX_RATIO3: rdata_d = {24'h000000, ratio_q[7:0]};
            IDX_FUNC1: rdata_d = 32'(en3_q) << EN3_BIT;
            IDX_FUNC2: rdata_d = 32'(fmt_q) << FMT_BIT;
            IDX_BW: rdata_d = 32'(bw_q) << BW_LSB;
            IDX_STATUS: rdata_d = (32'(applied_q) << BW_LSB)
               | (32'(lock_q) << ST_LOCK_BIT) | (32'(run_q) << ST_RUN_BIT);
            default: rdata_d = 32'h0000_0000;
         endcase
      end
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 8'h00;
         wstb_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstb_q <= wstb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers and bandwidth latch
   // ---------------------------------------------------------------
   always_comb begin
      en1_d = en1_q;
      en2_d = en2_q;
      en3_d = en3_q;
      fmt_d = fmt_q;
      bw_d = bw_q;
      ratio_d = ratio_q;
      if (wr_en && wstb_d) begin
         unique case (widx)
            IDX_ENABLE1: en1_d = wdata_d[EN1_BIT];
            IDX_GLOBAL: en2_d = wdata_d[EN2_BIT];
            IDX_RATIO0: ratio_d[31:24] = wdata_d;
            IDX_RATIO1: ratio_d[23:16] = wdata_d;
            IDX_RATIO2: ratio_d[15:8] = wdata_d;
            IDX_RATIO3: ratio_d[7:0] = wdata_d;
            IDX_FUNC1: en3_d = wdata_d[EN3_BIT];
            IDX_FUNC2: fmt_d = wdata_d[FMT_BIT];
            IDX_BW: bw_d = wdata_d[BW_LSB +: BW_W];
            default: ;
         endcase
      end
      run_d = en1_q & en2_q & en3_q;
      // new codes only reach the loop filter while unlocked; once lock is
      // seen the code captured just before it stays until lock drops
      applied_d = lock_q ? applied_q : bw_q;
      hz_d = 8'h01 << applied_d;
   end

   ratio_decode #(
      .RW(32)
   ) u_ratio_decode (
      .ratio_i(ratio_q),
      .fmt_i(fmt_q),
      .int_o(int_c),
      .frac_o(frac_c)
   );

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en1_q <= EN_RST;
         en2_q <= EN_RST;
         en3_q <= EN_RST;
         fmt_q <= FMT_RST;
         bw_q <= BW_RST;
         ratio_q <= RATIO_RST;
         run_q <= 1'b0;
         lock_q <= 1'b0;
         applied_q <= BW_RST;
         hz_q <= 8'h01;
         fmt_out_q <= FMT_RST;
         int_q <= 20'h00000;
         frac_q <= 20'h00000;
      end else begin
         en1_q <= en1_d;
         en2_q <= en2_d;
         en3_q <= en3_d;
         fmt_q <= fmt_d;
         bw_q <= bw_d;
         ratio_q <= ratio_d;
         run_q <= run_d;
         lock_q <= PLL_LOCK_I;
         applied_q <= applied_d;
         hz_q <= hz_d;
         fmt_out_q <= fmt_q;
         int_q <= int_c;
         frac_q <= frac_c;
      end
   end

   assign S_AXI_AWREADY_O = awready_q;
   assign S_AXI_WREADY_O = wready_q;
   assign S_AXI_BVALID_O = bvalid_q;
   assign S_AXI_BRESP_O = bresp_q;
   assign S_AXI_ARREADY_O = arready_q;
   assign S_AXI_RVALID_O = rvalid_q;
   assign S_AXI_RRESP_O = rresp_q;
   assign S_AXI_RDATA_O = rdata_q;
   assign RUN_O = run_q;
   assign RATIO_FMT_O = fmt_out_q;
   assign RATIO_INT_O = int_q;
   assign RATIO_FRAC_O = frac_q;
   assign LOOP_BW_CODE_O = applied_q;
   assign MIN_BW_HZ_O = hz_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_locked_twice;
      lock_q ##1 lock_q;
   endsequence
   sequence s_bw_read;
      ar_fire && ridx == IDX_BW;
   endsequence

   a_fmt_low_split: assert property (
      !$past(fmt_q) |-> RATIO_INT_O == $past(ratio_q[31:12])
         && RATIO_FRAC_O[19:8] == $past(ratio_q[11:0]))
      else $error("20.12 split wrong");
   a_fmt_high_split: assert property (
      $past(fmt_q) |-> RATIO_INT_O == {8'h00, $past(ratio_q[31:20])}
         && RATIO_FRAC_O == $past(ratio_q[19:0]))
      else $error("12.20 split wrong");
   a_bw_field_read: assert property (
      s_bw_read |=> S_AXI_RVALID_O
         && S_AXI_RDATA_O == {25'h0, $past(bw_q), 4'h0})
      else $error("bandwidth field readback wrong");
   a_bw_hz_map: assert property (
      MIN_BW_HZ_O == (8'h01 << LOOP_BW_CODE_O))
      else $error("bandwidth code to Hz wrong");
   a_bw_unlocked_follow: assert property (
      !lock_q |=> LOOP_BW_CODE_O == $past(bw_q))
      else $error("bandwidth not applied while unlocked");
   a_bw_locked_hold: assert property (
      s_locked_twice |-> $stable(LOOP_BW_CODE_O))
      else $error("bandwidth changed while locked");
   a_ratio_msb_first: assert property (
      wr_en && wstb_d && widx == IDX_RATIO0
         |=> ratio_q[31:24] == $past(wdata_d) ##1 RATIO_INT_O[19:12]
         == ratio_q[31:24] || fmt_out_q)
      else $error("ratio msb byte misplaced");
   a_run_gate: assert property (
      RUN_O |-> $past(en1_q) && $past(en2_q) && $past(en3_q))
      else $error("running without all enables");
   a_wr_resp_hold: assert property (
      wr_en |=> S_AXI_BVALID_O
         and (!S_AXI_BREADY_I |=> S_AXI_BVALID_O))
      else $error("write response lost");
endmodule : pll_cfg_top

// File: src/pll_cfg_pkg.sv
// register map and constants for the pll ratio and bandwidth configuration
package pll_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_ENABLE1 = 6'h03;
   localparam logic [5:0] IDX_GLOBAL = 6'h05;
   localparam logic [5:0] IDX_RATIO0 = 6'h06;
   localparam logic [5:0] IDX_RATIO1 = 6'h07;
   localparam logic [5:0] IDX_RATIO2 = 6'h08;
   localparam logic [5:0] IDX_RATIO3 = 6'h09;
   localparam logic [5:0] IDX_FUNC1 = 6'h16;
   localparam logic [5:0] IDX_FUNC2 = 6'h17;
   localparam logic [5:0] IDX_BW = 6'h1e;
   localparam logic [5:0] IDX_STATUS = 6'h20;
   // field positions
   localparam int EN1_BIT = 0;
   localparam int EN2_BIT = 0;
   localparam int EN3_BIT = 4;
   localparam int FMT_BIT = 3;
   localparam int BW_LSB = 4;
   localparam int BW_W = 3;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   // reset values
   localparam logic [31:0] RATIO_RST = 32'h0000_0000;
   localparam logic [2:0] BW_RST = 3'h0;
   localparam logic FMT_RST = 1'b0;
   localparam logic EN_RST = 1'b0;
   // ratio format codes
   localparam logic FMT_20_12 = 1'b0;
   localparam logic FMT_12_20 = 1'b1;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pll_cfg_pkg

// File: src/ratio_decode.sv
// splits the 32-bit ratio into integer and fraction per format
`timescale 1ns/100ps
module ratio_decode
   import pll_cfg_pkg::*;
#(
   parameter int RW = 32
) (
   input wire logic [RW-1:0] ratio_i, // raw ratio value
   input wire logic fmt_i, // format select
   output logic [19:0] int_o, // integer part, right aligned
   output logic [19:0] frac_o // fraction part, left aligned
);
   always_comb begin
      if (fmt_i == FMT_12_20) begin
         int_o = {8'h00, ratio_i[31:20]};
         frac_o = ratio_i[19:0];
      end else begin
         int_o = ratio_i[31:12];
         frac_o = {ratio_i[11:0], 8'h00};
      end
   end
endmodule : ratio_decode

// File: tb/pll_lock_model.sv
// behavioural loop core that reports lock after the reference settles
`timescale 1ns/100ps
module pll_lock_model #(
   parameter int LOCK_DLY = 8
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic ref_i, // reference clock present
   output logic lock_o // loop locked
);
   int cnt_q;

   // losing the reference drops lock at the next clock edge, the only unlock path besides reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 0;
      end else if (!ref_i) begin
         cnt_q <= 0;
      end else if (cnt_q < LOCK_DLY) begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign lock_o = (cnt_q == LOCK_DLY);
endmodule : pll_lock_model

// File: tb/pll_cfg_top_tb.sv
// self-checking bench for the ratio and loop bandwidth configuration
`timescale 1ns/100ps
module pll_cfg_top_tb;
   import pll_cfg_pkg::*;
   logic clk, rst_n, ref_on, lock;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, run, fmt;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [19:0] r_int, r_frac;
   logic [2:0] bw_code;
   logic [7:0] bw_hz;
   // host-scaled ratios: first one for 12.20, second one for 20.12
   logic [31:0] rv [2] = '{32'h0013a92a, 32'h2df5e208};
   int fails, checks_done, cyc;

   pll_cfg_top pll_cfg_top_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .PLL_LOCK_I(lock), .RUN_O(run),
      .RATIO_FMT_O(fmt), .RATIO_INT_O(r_int), .RATIO_FRAC_O(r_frac),
      .LOOP_BW_CODE_O(bw_code), .MIN_BW_HZ_O(bw_hz));

   pll_lock_model pll_lock_model_inst (.clk_i(clk), .rst_n_i(rst_n),
      .ref_i(ref_on), .lock_o(lock));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         complete_run();
      end
   end

   // ----------------------------------------
   // bus tasks and comparisons
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // upper data bits carry junk on purpose; only the low byte counts
   task automatic wr(input logic [5:0] idx, input logic [7:0] d,
      input logic [3:0] st, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'ha5a5a5, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp,
      input logic [1:0] er);
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      chk(rdata, exp);
      chk(32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask : rd_chk

   // outputs follow a commit by two cycles; one spare edge of margin
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic chk_bw(input logic [2:0] c);
      settle();
      chk(32'(bw_code), 32'(c));
      chk(32'(bw_hz), 32'h1 << c);
   endtask : chk_bw

   task automatic complete_run();
      if (fails == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_n, ref_on, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      fails = 0;
      checks_done = 0;
      cyc = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk_bw(3'h0);
      chk(32'(run), 32'h0);
      rd_chk(IDX_BW, 32'h0, RESP_OKAY);
      for (int c = 0; c < 8; c++) begin
         wr(IDX_BW, 8'(c << 4) | 8'h8f, 4'h1, RESP_OKAY);
         rd_chk(IDX_BW, 32'(c << 4), RESP_OKAY);
         chk_bw(3'(c));
      end
      for (int k = 0; k < 2; k++) begin
         for (int b = 0; b < 4; b++) begin
            wr(IDX_RATIO0 + 6'(b), rv[k][31-8*b -: 8], 4'h1, RESP_OKAY);
         end
         wr(IDX_FUNC2, k ? 8'h00 : 8'h08, 4'h1, RESP_OKAY);
         settle();
         chk(32'(fmt), k ? 32'h0 : 32'h1);
         chk(32'(r_int), k ? 32'(rv[k][31:12]) : 32'(rv[k][31:20]));
         chk(32'(r_frac), 32'(k ? {rv[k][11:0], 8'h0} : rv[k][19:0]));
         rd_chk(IDX_RATIO1, 32'(rv[k][23:16]), RESP_OKAY);
      end
      wr(6'h3f, 8'h55, 4'h1, RESP_SLVERR);
      wr(IDX_STATUS, 8'hff, 4'h1, RESP_SLVERR);
      rd_chk(6'h3f, 32'h0, RESP_SLVERR);
      wr(IDX_BW, 8'h30, 4'h0, RESP_OKAY);
      rd_chk(IDX_BW, 32'h70, RESP_OKAY);
      wr(IDX_BW, 8'h30, 4'h1, RESP_OKAY);
      wr(IDX_FUNC1, 8'h10, 4'h1, RESP_OKAY);
      wr(IDX_GLOBAL, 8'h01, 4'h1, RESP_OKAY);
      settle();
      chk(32'(run), 32'h0);
      wr(IDX_ENABLE1, 8'h01, 4'h1, RESP_OKAY);
      settle();
      chk(32'(run), 32'h1);
      ref_on <= 1'b1;
      repeat (12) @(posedge clk);
      wr(IDX_BW, 8'h60, 4'h1, RESP_OKAY);
      chk_bw(3'h3);
      rd_chk(IDX_STATUS, 32'h33, RESP_OKAY);
      rd_chk(IDX_BW, 32'h60, RESP_OKAY);
      ref_on <= 1'b0;
      settle();
      chk_bw(3'h6);
      wr(IDX_GLOBAL, 8'h00, 4'h1, RESP_OKAY);
      settle();
      chk(32'(run), 32'h0);
      complete_run();
   end
endmodule : pll_cfg_top_tb
